// file: sim/test_video_output_format_ctrl.sv
// Self-checking bench for the video output formatter.
// Assumes the package, design, checker and display model compile first.
`timescale 1ns/1ns
`default_nettype none
// ====================
// Bench
module test_video_output_format_ctrl;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pix_valid, pix_ready, clk_out, clk_oe, hs_out, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  vofc_pkg::vofc_pixel_type pix_in;
  logic [7:0] rp, gp, bp, rs, gs, bs, fmt_r;
  logic [5:0] byte_oe;
  logic [9:0] off_g;
  int num_errors, comparisons;
  always #25 pclk = ~pclk;
  vofc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_in(pix_in), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .red_primary_byte(rp), .green_primary_byte(gp), .blue_primary_byte(bp),
    .red_secondary_byte(rs), .green_secondary_byte(gs), .blue_secondary_byte(bs), .byte_oe(byte_oe),
    .output_pixel_clock(clk_out), .output_pixel_clock_oe(clk_oe), .hsync_output(hs_out), .vsync_output(),
    .offset_red(), .offset_green(off_g), .offset_blue());
  vofc_display_model partner (.output_pixel_clock(clk_out), .prim_bytes({rp, gp, bp}), .sec_bytes({rs, gs, bs}),
    .byte_oe(byte_oe), .hsync_output(hs_out), .fmt(fmt_r));
  // ====================
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic fail_timeout;
    num_errors++;
    $display("[FAIL] handshake expected answer seen timeout");
    test_done;
  endtask
  // Holds the request until pready is sampled high, then releases
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) fail_timeout;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // ====================
  // Scenarios
  task automatic scn_reset_regs;
    logic [11:0] a [6] = '{12'h050, 12'h054, 12'h05c, 12'h060, 12'h064, 12'h068};
    logic [7:0] v [6] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h10, 8'h00};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, a[i], 32'h0000_0000);
      check("reset value", {24'h00_0000, v[i]}, rd);
    end
    apb(1'b0, 12'h0fc, 32'h0000_0000);
    check("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
    check("unmapped data", 32'h0000_0000, rd);
    apb(1'b1, 12'h065, 32'h0000_0001);
    check("misaligned error", 32'h0000_0001, {31'h0000_0000, err});
    apb(1'b0, 12'h064, 32'h0000_0000);
    check("width untouched", 32'h0000_0010, rd);
  endtask
  task automatic scn_cfg_codes;
    logic [31:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {25'h000_0000, i[2:0], i[1:0], 2'b00};
      apb(1'b1, 12'h05c, v);
      apb(1'b0, 12'h05c, 32'h0000_0000);
      check("black cfg", v, rd);
    end
  endtask
  task automatic scn_tristate;
    logic [7:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      apb(1'b1, 12'h068, {24'h00_0000, m});
      apb(1'b0, 12'h060, 32'h0000_0000);
      check("byte enables", {26'h000_0000, ~m[5:0]}, {26'h000_0000, byte_oe});
      check("clock enable", {31'h0000_0000, ~(m[6] | m[7])}, {31'h0000_0000, clk_oe});
    end
  endtask
  // One line of 40 pixels; input sync on pixel 0, width register 4
  task automatic scn_line(input logic [7:0] fmt, input logic [7:0] tri_v, input logic [7:0] cfg);
    vofc_pkg::vofc_pixel_type px;
    logic [9:0] og;
    logic [7:0] r, b, p;
    int n, full;
    fmt_r <= fmt;
    apb(1'b1, 12'h060, {24'h00_0000, fmt});
    apb(1'b1, 12'h068, {24'h00_0000, tri_v});
    apb(1'b1, 12'h05c, {24'h00_0000, cfg});
    og = off_g;
    full = 0;
    for (int k = 0; k < 40; k++) begin
      p = k[7:0];
      px = {k == 0, 1'b0, 8'h10 + p, 8'h40 + p, 8'h80 + p};
      pix_in <= px;
      pix_valid <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
        if (pix_ready !== 1'b1) full++;
      end while (pix_ready !== 1'b1 && n < 50);
      if (n == 50) fail_timeout;
    end
    pix_valid <= 1'b0;
    check("input refused when full", 32'h0000_0001, {31'h0000_0000, full > 0});
    n = 0;
    do begin
      apb(1'b0, 12'h0c0, 32'h0000_0000);
      n++;
    end while (rd[4:0] !== 5'h00 && n < 100);
    check("fifo drained", 32'h0000_0000, {27'h000_0000, rd[4:0]});
    check("hsync samples", fmt[0] ? 2 : 4, partner.hs_cnt);
    for (int k = 0; k < 12; k++) begin
      p = k[7:0] + 8'h04;
      r = 8'h10 + p;
      b = 8'h80 + p;
      if (fmt[4] && !k[0]) r = b;
      if (fmt[4]) b = 8'h00;
      if (fmt[0] && tri_v[1] && (k[0] ^ fmt[2])) r = 8'h00;
      check("captured pixel", {8'h00, r, 8'h40 + p, b}, {8'h00, partner.cap[k]});
    end
    if (cfg[0]) check("offset held", {22'h00_0000, og}, {22'h00_0000, off_g});
    else check("offset moved", 32'h0000_0001, {31'h0000_0000, off_g !== og});
  endtask
  // ====================
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, pix_valid} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pix_in = '0;
    fmt_r = 8'h00;
    num_errors = 0;
    comparisons = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    scn_reset_regs;
    scn_cfg_codes;
    apb(1'b1, 12'h064, 32'h0000_0004);
    scn_line(8'h00, 8'h00, 8'h00);
    scn_line(8'he0, 8'h00, 8'h01);
    scn_line(8'h01, 8'h00, 8'h01);
    scn_line(8'h07, 8'h02, 8'h01);
    scn_line(8'h10, 8'h00, 8'h01);
    scn_tristate;
    test_done;
  end
endmodule // test_video_output_format_ctrl
`default_nettype wire

// file: sim/vofc_display_model.sv
// Downstream display logic: samples pixels on the output clock.
// Assumes fmt mirrors the format register written by the bench.
`timescale 1ns/1ns
`default_nettype none
// ====================
// Display model
module vofc_display_model (
  input wire logic output_pixel_clock,
  input wire logic [23:0] prim_bytes,
  input wire logic [23:0] sec_bytes,
  input wire logic [5:0] byte_oe,
  input wire logic hsync_output,
  input wire logic [7:0] fmt
);
  // Floating bytes read low through the pin pull-downs
  wire logic [23:0] prim = prim_bytes & {{8{byte_oe[0]}}, {8{byte_oe[2]}}, {8{byte_oe[4]}}};
  wire logic [23:0] sec = sec_bytes & {{8{byte_oe[1]}}, {8{byte_oe[3]}}, {8{byte_oe[5]}}};
  wire logic hs_act = hsync_output ^ fmt[7];
  wire logic samp = output_pixel_clock ^ fmt[5];
  logic [23:0] cap [0:31];
  logic [23:0] sec_lat = 24'h00_0000;
  int idx = 0;
  int hs_cnt = 0;
  logic hs_prev = 1'b0;
  // Sample on the edge opposite the change edge, where data is settled
  always @(output_pixel_clock) begin
    if (samp) begin
      if (hs_act) begin
        hs_cnt = hs_prev ? hs_cnt + 1 : 1;
        idx = 0;
      end else if (idx < 30) begin
        cap[idx + int'(fmt[0] & fmt[2])] = prim;
        if (fmt[0]) cap[idx + int'(!fmt[2])] = fmt[1] ? sec_lat : sec;
        idx = idx + (fmt[0] ? 2 : 1);
      end
      hs_prev = hs_act;
    end else begin
      // Interleaved secondary leads its primary by half a clock
      sec_lat = sec;
    end
  end
endmodule // vofc_display_model
`default_nettype wire

// file: sim/vofc_top_assertions.sv
// Concurrent checks on the formatter's register bus and pins.
// Assumes binding into vofc_top; one clock domain, pclk.
`timescale 1ns/1ns
`default_nettype none
// ====================
// Checker
module vofc_top_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic [7:0] red_secondary_byte,
  input wire logic [7:0] green_secondary_byte,
  input wire logic [7:0] blue_secondary_byte,
  input wire logic [5:0] byte_oe,
  input wire logic output_pixel_clock_oe,
  input wire logic hsync_output,
  input wire logic vsync_output,
  input wire logic [9:0] offset_green
);
  localparam logic [11:0] A_CFG = 12'h05c;
  localparam logic [11:0] A_FMT = 12'h060;
  localparam logic [11:0] A_HSW = 12'h064;
  localparam logic [11:0] A_TRI = 12'h068;
  logic [7:0] cfg_q, fmt_q, hsw_q, tri_q;
  logic [3:0] age_q;
  logic wide_q, pix_q;
  wire logic wr = psel & penable & pready & pwrite & ~pslverr;
  wire logic rd_known = pready & ~pwrite & (paddr == A_CFG || paddr == A_FMT || paddr == A_HSW);
  wire logic [7:0] exp_rd = (paddr == A_CFG) ? cfg_q : (paddr == A_FMT) ? fmt_q : hsw_q;
  // Settling age: outputs are flops, so only judge them once a write has aged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cfg_q, fmt_q, hsw_q, tri_q} <= 32'h4000_1000;
      age_q <= 4'hf;
      {wide_q, pix_q} <= 2'b00;
    end else begin
      if (wr && paddr == A_CFG) cfg_q <= pwdata[7:0] & vofc_pkg::MASK_BLACK_CFG;
      if (wr && paddr == A_FMT) fmt_q <= pwdata[7:0] & vofc_pkg::MASK_OUT_FMT;
      if (wr && paddr == A_HSW) hsw_q <= pwdata[7:0];
      if (wr && paddr == A_TRI) tri_q <= pwdata[7:0];
      age_q <= wr ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
      wide_q <= wide_q | fmt_q[0];
      pix_q <= pix_q | (pix_valid & pix_ready);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_misaligned: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_reg_readback: assert property (rd_known |-> prdata[7:0] == exp_rd)
    else $error("register read back wrong");
  a_narrow_sec_low: assert property (!wide_q && !fmt_q[0] |-> {red_secondary_byte, green_secondary_byte,
    blue_secondary_byte} == 24'h00_0000)
    else $error("secondary bytes not low in narrow mode");
  a_float_bytes: assert property (age_q > 4'h3 |-> byte_oe == ~tri_q[5:0])
    else $error("byte enables differ from float bits");
  a_float_clock: assert property (age_q > 4'h3 |-> output_pixel_clock_oe == !(tri_q[6] | tri_q[7]))
    else $error("clock enable differs from float bits");
  a_sync_idle: assert property (!pix_q && age_q > 4'h3 |-> hsync_output == fmt_q[7] &&
    vsync_output == fmt_q[6])
    else $error("idle sync level wrong");
  a_offset_frozen: assert property (cfg_q[0] && age_q > 4'h3 |=> $stable(offset_green))
    else $error("offset moved while loop disabled");
endmodule // vofc_top_checker

bind vofc_top vofc_top_checker u_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pix_valid(pix_valid), .pix_ready(pix_ready), .red_secondary_byte(red_secondary_byte),
  .green_secondary_byte(green_secondary_byte), .blue_secondary_byte(blue_secondary_byte), .byte_oe(byte_oe),
  .output_pixel_clock_oe(output_pixel_clock_oe), .hsync_output(hsync_output), .vsync_output(vsync_output),
  .offset_green(offset_green));
`default_nettype wire

// file: verilog/vofc_pkg.sv
// Constants, register map and carrier types of the video output formatter.
// Assumes one clock domain and an APB register slave in front of it.
package vofc_pkg;
  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_BLACK_START_HI = 8'h14;
  localparam logic [7:0] IDX_BLACK_START_LO = 8'h15;
  localparam logic [7:0] IDX_BLACK_CFG = 8'h17;
  localparam logic [7:0] IDX_OUT_FMT = 8'h18;
  localparam logic [7:0] IDX_HS_WIDTH = 8'h19;
  localparam logic [7:0] IDX_TRISTATE = 8'h1a;
  localparam logic [7:0] IDX_STATUS = 8'h30;
  // ==========================================================================
  // Reset values and writable-bit masks
  localparam logic [7:0] RST_BLACK_START_HI = 8'h00;
  localparam logic [7:0] RST_BLACK_START_LO = 8'h00;
  localparam logic [7:0] RST_BLACK_CFG = 8'h40;
  localparam logic [7:0] RST_OUT_FMT = 8'h00;
  localparam logic [7:0] RST_HS_WIDTH = 8'h10;
  localparam logic [7:0] RST_TRISTATE = 8'h00;
  localparam logic [7:0] MASK_BLACK_START_HI = 8'h1f;
  localparam logic [7:0] MASK_BLACK_CFG = 8'h7d;
  localparam logic [7:0] MASK_OUT_FMT = 8'hf7;
  // ==========================================================================
  // Field positions
  localparam int BLC_DIS_BIT = 0;
  localparam int BLC_WIDTH_LSB = 2;
  localparam int BLC_BW_LSB = 4;
  localparam int FMT_WIDE_BIT = 0;
  localparam int FMT_ILV_BIT = 1;
  localparam int FMT_SWAP_BIT = 2;
  localparam int FMT_422_BIT = 4;
  localparam int FMT_CLKPOL_BIT = 5;
  localparam int FMT_VSPOL_BIT = 6;
  localparam int FMT_HSPOL_BIT = 7;
  localparam int TRI_CLK_A_BIT = 6;
  localparam int TRI_CLK_B_BIT = 7;
  // ==========================================================================
  // Black level loop and FIFO constants
  localparam logic [4:0] BLC_TC_BASE = 5'h05;
  localparam logic [2:0] BLC_AVG_BASE = 3'h4;
  localparam logic [7:0] BLC_TARGET = 8'h00;
  localparam logic [9:0] BLC_OFFSET_MID = 10'h200;
  localparam int FIFO_DEPTH = 16;
  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic hs;
    logic vs;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } vofc_pixel_type;

  typedef enum logic [1:0] {
    BLK_IDLE = 2'b00,
    BLK_WAIT = 2'b01,
    BLK_SAMPLE = 2'b10,
    BLK_UPDATE = 2'b11
  } vofc_blk_state_type;
endpackage : vofc_pkg

// file: verilog/vofc_top.sv
// Pixel output formatter with black level loop, FIFO and APB register slave.
// Assumes the pixel stream and APB both run on pclk; one output pixel per two pclk.
`timescale 1ns/1ns
`default_nettype none

// ============================================================================
// Synchronous FIFO
module vofc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire wr_fire = wr_valid & wr_ready;
  wire rd_fire = rd_valid & rd_ready;

  assign wr_ready = (cnt_q != DEPTH[AW:0]);
  assign rd_valid = (cnt_q != '0);
  assign rd_data = mem_q[rp_q];
  assign level = cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (wr_fire) wp_q <= wp_q + 1'b1;
      if (rd_fire) rp_q <= rp_q + 1'b1;
      if (wr_fire && !rd_fire) cnt_q <= cnt_q + 1'b1;
      else if (rd_fire && !wr_fire) cnt_q <= cnt_q - 1'b1;
    end
  end

  // Storage needs no reset; reads are gated by the count
  always_ff @(posedge clk) begin
    if (wr_fire) mem_q[wp_q] <= wr_data;
  end
endmodule // vofc_fifo

// ============================================================================
// Top level
module vofc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire vofc_pkg::vofc_pixel_type pix_in,
  input wire logic pix_valid,
  output logic pix_ready,
  output logic [7:0] red_primary_byte,
  output logic [7:0] green_primary_byte,
  output logic [7:0] blue_primary_byte,
  output logic [7:0] red_secondary_byte,
  output logic [7:0] green_secondary_byte,
  output logic [7:0] blue_secondary_byte,
  output logic [5:0] byte_oe,
  output logic output_pixel_clock,
  output logic output_pixel_clock_oe,
  output logic hsync_output,
  output logic vsync_output,
  output logic [9:0] offset_red,
  output logic [9:0] offset_green,
  output logic [9:0] offset_blue
);
  // ==========================================================================
  // Register file
  logic [7:0] start_hi_q;
  logic [7:0] start_lo_q;
  logic [7:0] blk_cfg_q;
  logic [7:0] fmt_q;
  logic [7:0] hs_width_q;
  logic [5:0] byte_oe_q;
  logic clk_oe_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [4:0] fifo_level;
  vofc_pkg::vofc_blk_state_type blk_st_q;

  wire [7:0] idx = paddr[9:2];
  wire aligned = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
  wire hit_shi = aligned && (idx == vofc_pkg::IDX_BLACK_START_HI);
  wire hit_slo = aligned && (idx == vofc_pkg::IDX_BLACK_START_LO);
  wire hit_cfg = aligned && (idx == vofc_pkg::IDX_BLACK_CFG);
  wire hit_fmt = aligned && (idx == vofc_pkg::IDX_OUT_FMT);
  wire hit_hsw = aligned && (idx == vofc_pkg::IDX_HS_WIDTH);
  wire hit_tri = aligned && (idx == vofc_pkg::IDX_TRISTATE);
  wire hit_sts = aligned && (idx == vofc_pkg::IDX_STATUS);
  wire mapped = hit_shi | hit_slo | hit_cfg | hit_fmt | hit_hsw | hit_tri | hit_sts;
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;
  wire [7:0] tri_val = {~clk_oe_q, ~clk_oe_q, ~byte_oe_q};
  wire blk_busy = (blk_st_q != vofc_pkg::BLK_IDLE);
  wire [7:0] status_val = {2'b00, blk_busy, fifo_level};
  wire [7:0] rd_val = hit_shi ? start_hi_q :
                      hit_slo ? start_lo_q :
                      hit_cfg ? blk_cfg_q :
                      hit_fmt ? fmt_q :
                      hit_hsw ? hs_width_q :
                      hit_tri ? tri_val :
                      hit_sts ? status_val : 8'h00;
  wire [7:0] wd = pwdata[7:0];

  // Reserved bits are masked so they always read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_hi_q <= vofc_pkg::RST_BLACK_START_HI;
      start_lo_q <= vofc_pkg::RST_BLACK_START_LO;
      blk_cfg_q <= vofc_pkg::RST_BLACK_CFG;
      fmt_q <= vofc_pkg::RST_OUT_FMT;
      hs_width_q <= vofc_pkg::RST_HS_WIDTH;
    end else if (wr_en) begin
      if (hit_shi) start_hi_q <= wd & vofc_pkg::MASK_BLACK_START_HI;
      if (hit_slo) start_lo_q <= wd;
      if (hit_cfg) blk_cfg_q <= wd & vofc_pkg::MASK_BLACK_CFG;
      if (hit_fmt) fmt_q <= wd & vofc_pkg::MASK_OUT_FMT;
      if (hit_hsw) hs_width_q <= wd;
    end
  end

  // Float bits are kept as enables so the pin enables come straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_oe_q <= ~vofc_pkg::RST_TRISTATE[5:0];
      clk_oe_q <= 1'b1;
    end else if (wr_en && hit_tri) begin
      byte_oe_q <= ~wd[5:0];
      clk_oe_q <= ~(wd[vofc_pkg::TRI_CLK_A_BIT] | wd[vofc_pkg::TRI_CLK_B_BIT]);
    end
  end

  // One wait-free access phase; unmapped addresses answer with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= {24'h00_0000, rd_val};
      pready_q <= 1'b1;
      pslverr_q <= ~mapped;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ==========================================================================
  // Input FIFO
  vofc_pkg::vofc_pixel_type fifo_out;
  logic fifo_valid;
  logic pop_slot;

  vofc_fifo #(
    .WIDTH($bits(vofc_pkg::vofc_pixel_type)),
    .DEPTH(vofc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .wr_data(pix_in),
    .wr_valid(pix_valid),
    .wr_ready(pix_ready),
    .rd_data(fifo_out),
    .rd_valid(fifo_valid),
    .rd_ready(pop_slot),
    .level(fifo_level)
  );

  // ==========================================================================
  // Output clock and edge selection
  logic ph_q;
  logic clk_q;
  wire wide = fmt_q[vofc_pkg::FMT_WIDE_BIT];
  wire ilv = wide & fmt_q[vofc_pkg::FMT_ILV_BIT];
  wire swap = fmt_q[vofc_pkg::FMT_SWAP_BIT];
  wire f422 = ~wide & fmt_q[vofc_pkg::FMT_422_BIT];
  wire cpol = fmt_q[vofc_pkg::FMT_CLKPOL_BIT];
  // Wide mode halves the output clock: two pixels per period
  wire tog = ~wide | ph_q;
  wire clk_d = tog ? ~clk_q : clk_q;
  wire prim_edge = tog & (clk_d == cpol);
  wire sec_edge = tog & (clk_d == (cpol ^ ilv));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 1'b0;
      clk_q <= 1'b0;
    end else begin
      ph_q <= ~ph_q;
      clk_q <= clk_d;
    end
  end

  // ==========================================================================
  // Horizontal sync shaping and bus steering
  logic [7:0] hcnt_q;
  logic last_hs_q;
  logic sel_q;
  logic cph_q;
  logic hs_stage_q;
  logic vs_stage_q;
  logic [23:0] stage_p_q;
  logic [23:0] stage_s_q;
  wire hs_rise = fifo_out.hs & ~last_hs_q;
  wire hs_trail = ~hs_rise & (hcnt_q == 8'h01);
  wire [7:0] hcnt_d = hs_rise ? hs_width_q : (hcnt_q != 8'h00) ? hcnt_q - 8'h01 : 8'h00;
  // Pair and chroma phase restart on the pixel itself, not the one after
  wire sel_cur = (hs_rise | hs_trail) ? swap : sel_q;
  wire cph_cur = ~hs_trail & cph_q;
  // Wide mode holds a pair's first pixel for a primary edge, keeping pairs aligned
  assign pop_slot = wide ? (ph_q & (prim_edge | (sel_cur != swap))) : prim_edge;
  wire pop = pop_slot & fifo_valid;
  wire [7:0] chroma = cph_cur ? fifo_out.r : fifo_out.b;
  wire [23:0] narrow_pix = f422 ? {chroma, fifo_out.g, 8'h00} : {fifo_out.r, fifo_out.g, fifo_out.b};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_q <= 8'h00;
      last_hs_q <= 1'b0;
      sel_q <= 1'b0;
      cph_q <= 1'b0;
      hs_stage_q <= 1'b0;
      vs_stage_q <= 1'b0;
    end else if (pop) begin
      last_hs_q <= fifo_out.hs;
      hcnt_q <= hcnt_d;
      hs_stage_q <= (hcnt_d != 8'h00);
      vs_stage_q <= fifo_out.vs;
      sel_q <= ~sel_cur;
      cph_q <= ~cph_cur;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_p_q <= 24'h00_0000;
      stage_s_q <= 24'h00_0000;
    end else if (pop) begin
      if (!wide) stage_p_q <= narrow_pix;
      else if (!sel_cur) stage_p_q <= {fifo_out.r, fifo_out.g, fifo_out.b};
      else stage_s_q <= {fifo_out.r, fifo_out.g, fifo_out.b};
    end
  end

  // ==========================================================================
  // Output pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {red_primary_byte, green_primary_byte, blue_primary_byte} <= 24'h00_0000;
      hsync_output <= 1'b0;
      vsync_output <= 1'b0;
    end else if (prim_edge) begin
      {red_primary_byte, green_primary_byte, blue_primary_byte} <= stage_p_q;
      hsync_output <= hs_stage_q ^ fmt_q[vofc_pkg::FMT_HSPOL_BIT];
      vsync_output <= vs_stage_q ^ fmt_q[vofc_pkg::FMT_VSPOL_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {red_secondary_byte, green_secondary_byte, blue_secondary_byte} <= 24'h00_0000;
    end else if (!wide) begin
      {red_secondary_byte, green_secondary_byte, blue_secondary_byte} <= 24'h00_0000;
    end else if (sec_edge) begin
      {red_secondary_byte, green_secondary_byte, blue_secondary_byte} <= stage_s_q;
    end
  end

  // Enables bypass all format logic, so a float bit always wins
  assign byte_oe = byte_oe_q;
  assign output_pixel_clock = clk_q;
  assign output_pixel_clock_oe = clk_oe_q;

  // ==========================================================================
  // Black level loop, fed from the accepted input stream
  logic in_hs_q;
  logic [12:0] pos_q;
  logic [6:0] nsamp_q;
  logic [14:0] sum_q [3];
  logic signed [21:0] integ_q [3];
  logic [9:0] off_q [3];
  wire in_fire = pix_valid & pix_ready;
  wire in_trail = in_hs_q & ~pix_in.hs;
  wire [12:0] start_pos = {start_hi_q[4:0], start_lo_q};
  wire [1:0] wsel = blk_cfg_q[vofc_pkg::BLC_WIDTH_LSB +: 2];
  wire [2:0] bw = blk_cfg_q[vofc_pkg::BLC_BW_LSB +: 3];
  wire blk_dis = blk_cfg_q[vofc_pkg::BLC_DIS_BIT];
  wire [6:0] nlast = 7'((8'h10 << wsel) - 8'h01);
  wire [2:0] avg_sh = vofc_pkg::BLC_AVG_BASE + {1'b0, wsel};
  wire [4:0] tc_sh = vofc_pkg::BLC_TC_BASE + {2'b00, bw};
  wire [7:0] in_ch [3];
  assign in_ch[0] = pix_in.r;
  assign in_ch[1] = pix_in.g;
  assign in_ch[2] = pix_in.b;
  wire take = in_fire & (((blk_st_q == vofc_pkg::BLK_WAIT) && (pos_q == start_pos)) ||
                         (blk_st_q == vofc_pkg::BLK_SAMPLE));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_hs_q <= 1'b0;
      pos_q <= 13'h0000;
      nsamp_q <= 7'h00;
      blk_st_q <= vofc_pkg::BLK_IDLE;
    end else begin
      if (in_fire) in_hs_q <= pix_in.hs;
      case (blk_st_q)
        vofc_pkg::BLK_IDLE: begin
          if (in_fire && in_trail) begin
            pos_q <= 13'h0000;
            blk_st_q <= vofc_pkg::BLK_WAIT;
          end
        end
        vofc_pkg::BLK_WAIT: begin
          if (take) begin
            nsamp_q <= 7'h01;
            blk_st_q <= (nlast == 7'h00) ? vofc_pkg::BLK_UPDATE : vofc_pkg::BLK_SAMPLE;
          end else if (in_fire) begin
            pos_q <= pos_q + 13'h0001;
          end
        end
        vofc_pkg::BLK_SAMPLE: begin
          if (take) begin
            nsamp_q <= nsamp_q + 7'h01;
            if (nsamp_q == nlast) blk_st_q <= vofc_pkg::BLK_UPDATE;
          end
        end
        vofc_pkg::BLK_UPDATE: blk_st_q <= vofc_pkg::BLK_IDLE;
        default: blk_st_q <= vofc_pkg::BLK_IDLE;
      endcase
    end
  end

  // Integrator gain of two to minus the shift sets the line time constant
  genvar c;
  for (c = 0; c < 3; c++) begin : g_ch
    wire [14:0] avg = sum_q[c] >> avg_sh;
    wire signed [21:0] err = $signed({14'h0000, vofc_pkg::BLC_TARGET}) - $signed({14'h0000, avg[7:0]});
    wire signed [21:0] integ_n = integ_q[c] + err;
    wire signed [21:0] corr = integ_n >>> tc_sh;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sum_q[c] <= 15'h0000;
        integ_q[c] <= 22'sh00_0000;
        off_q[c] <= vofc_pkg::BLC_OFFSET_MID;
      end else if (blk_st_q == vofc_pkg::BLK_IDLE) begin
        sum_q[c] <= 15'h0000;
      end else if (take) begin
        sum_q[c] <= sum_q[c] + {7'h00, in_ch[c]};
      end else if (blk_st_q == vofc_pkg::BLK_UPDATE && !blk_dis) begin
        integ_q[c] <= integ_n;
        off_q[c] <= vofc_pkg::BLC_OFFSET_MID + corr[9:0];
      end
    end
  end

  assign offset_red = off_q[0];
  assign offset_green = off_q[1];
  assign offset_blue = off_q[2];
endmodule // vofc_top

`default_nettype wire
